// *** common/ftc_pkg.sv ***
package ftc_pkg;
  localparam int FTC_CNT_W = 16;
  localparam logic [7:0] FTC_SEL_RST = 8'h00;
  localparam logic [7:0] FTC_CTL0_RST = 8'h00;
  localparam logic [15:0] FTC_CNT_RST = 16'h0000;
  localparam int FTC_SEL_B_MSB = 7;
  localparam int FTC_SEL_B_LSB = 4;
  localparam int FTC_SEL_A_MSB = 3;
  localparam int FTC_SEL_A_LSB = 0;
  localparam int FTC_DIV_MSB = 1;
  localparam int FTC_DIV_LSB = 0;
  localparam logic [2:0] FTC_LAST_BIT = 3'h7;

  // command bytes
  localparam logic [7:0] FTC_OPC_RD_TIMER = 8'hFA;
  localparam logic [7:0] FTC_OPC_CLR_TIMER = 8'h56;
  localparam logic [7:0] FTC_OPC_WR_SEL = 8'h1A;
  localparam logic [7:0] FTC_OPC_RD_SEL = 8'h9A;
  localparam logic [7:0] FTC_OPC_WR_CTL0 = 8'h14;
  localparam logic [7:0] FTC_OPC_RD_CTL0 = 8'hD2;

  // bit positions in the interrupt flag register
  localparam int FTC_IF_F0 = 0;
  localparam int FTC_IF_F1 = 1;
  localparam int FTC_IF_WAKE = 2;
  localparam int FTC_IF_MODE_CHG = 3;
  localparam int FTC_IF_BUS_ERR = 4;
  localparam int FTC_IF_TXDONE = 5;
  localparam int FTC_IF_RXQ = 6;
  localparam int FTC_IF_RXTEMP = 7;
  // bit positions in the status flag register
  localparam int FTC_SF_RXFULL = 0;
  localparam int FTC_SF_RXEMPTY = 1;
  localparam int FTC_SF_BUS_OFF = 2;
  localparam int FTC_SF_ERR_PASV = 3;
  localparam int FTC_SF_TXHALF = 4;
  localparam int FTC_SF_TXEMPTY = 5;

  // selector codes
  localparam logic [3:0] FTC_PICK_F0 = 4'h0;
  localparam logic [3:0] FTC_PICK_F1 = 4'h1;
  localparam logic [3:0] FTC_PICK_WAKE = 4'h2;
  localparam logic [3:0] FTC_PICK_MODE_CHG = 4'h3;
  localparam logic [3:0] FTC_PICK_BUS_ERR = 4'h4;
  localparam logic [3:0] FTC_PICK_TXDONE = 4'h5;
  localparam logic [3:0] FTC_PICK_RXQ = 4'h6;
  localparam logic [3:0] FTC_PICK_RXTEMP = 4'h7;
  localparam logic [3:0] FTC_PICK_RXFULL = 4'h8;
  localparam logic [3:0] FTC_PICK_RXEMPTY = 4'h9;
  localparam logic [3:0] FTC_PICK_BUS_OFF = 4'hA;
  localparam logic [3:0] FTC_PICK_ERR_PASV = 4'hB;
  localparam logic [3:0] FTC_PICK_TXHALF = 4'hC;
  localparam logic [3:0] FTC_PICK_TXEMPTY = 4'hD;

  // divider codes
  localparam logic [1:0] FTC_DIV_1 = 2'h0;
  localparam logic [1:0] FTC_DIV_2 = 2'h1;
  localparam logic [1:0] FTC_DIV_4 = 2'h2;
  localparam logic [1:0] FTC_DIV_8 = 2'h3;

  typedef enum logic [2:0] {
    FTC_ST_CMD,
    FTC_ST_WR_SEL,
    FTC_ST_WR_CTL,
    FTC_ST_SEND,
    FTC_ST_SKIP
  } ftc_spi_st_e;

  function automatic logic ftc_flag_pick(input logic [3:0] sel,
                                         input logic [7:0] int_flags,
                                         input logic [7:0] stat_flags);
    logic r;
    r = 1'b0;
    unique case (sel)
      FTC_PICK_F0: r = int_flags[FTC_IF_F0];
      FTC_PICK_F1: r = int_flags[FTC_IF_F1];
      FTC_PICK_WAKE: r = int_flags[FTC_IF_WAKE];
      FTC_PICK_MODE_CHG: r = int_flags[FTC_IF_MODE_CHG];
      FTC_PICK_BUS_ERR: r = int_flags[FTC_IF_BUS_ERR];
      FTC_PICK_TXDONE: r = int_flags[FTC_IF_TXDONE];
      FTC_PICK_RXQ: r = int_flags[FTC_IF_RXQ];
      FTC_PICK_RXTEMP: r = int_flags[FTC_IF_RXTEMP];
      FTC_PICK_RXFULL: r = stat_flags[FTC_SF_RXFULL];
      FTC_PICK_RXEMPTY: r = stat_flags[FTC_SF_RXEMPTY];
      FTC_PICK_BUS_OFF: r = stat_flags[FTC_SF_BUS_OFF];
      FTC_PICK_ERR_PASV: r = stat_flags[FTC_SF_ERR_PASV];
      FTC_PICK_TXHALF: r = stat_flags[FTC_SF_TXHALF];
      FTC_PICK_TXEMPTY: r = stat_flags[FTC_SF_TXEMPTY];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : ftc_flag_pick

  function automatic logic [2:0] ftc_div_mask(input logic [1:0] div);
    logic [2:0] m;
    m = 3'h0;
    unique case (div)
      FTC_DIV_1: m = 3'h0;
      FTC_DIV_2: m = 3'h1;
      FTC_DIV_4: m = 3'h3;
      FTC_DIV_8: m = 3'h7;
    endcase
    return m;
  endfunction : ftc_div_mask
endpackage : ftc_pkg

// *** hw/ftc_flag_pin_mux.sv ***
`timescale 1ns/1ps
module ftc_flag_pin_mux (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // selection and flags
  input wire logic [7:0] i_sel,
  input wire logic [7:0] i_int_flags,
  input wire logic [7:0] i_stat_flags,
  // pins
  output logic o_pin_a,
  output logic o_pin_b
);
  import ftc_pkg::*;

  logic [3:0] sel_a;
  logic [3:0] sel_b;
  assign sel_a = i_sel[FTC_SEL_A_MSB:FTC_SEL_A_LSB];
  assign sel_b = i_sel[FTC_SEL_B_MSB:FTC_SEL_B_LSB];

  // one register stage keeps the pins glitch free on selector changes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin_a <= 1'b0;
      o_pin_b <= 1'b0;
    end else begin
      o_pin_a <= ftc_flag_pick(sel_a,
                               i_int_flags,
                               i_stat_flags);
      o_pin_b <= ftc_flag_pick(sel_b,
                               i_int_flags,
                               i_stat_flags);
    end
  end

  a_pin_a_follows: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    ##1 o_pin_a == ftc_flag_pick($past(sel_a), $past(i_int_flags),
                                 $past(i_stat_flags)))
    else $error("pin a does not follow its selected flag");
  a_bus_off_pin_b: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    sel_b == FTC_PICK_BUS_OFF
    |=> o_pin_b == $past(i_stat_flags[FTC_SF_BUS_OFF]))
    else $error("pin b does not follow bus disconnected flag");
  a_err_pasv_pin_b: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    sel_b == FTC_PICK_ERR_PASV
    |=> o_pin_b == $past(i_stat_flags[FTC_SF_ERR_PASV]))
    else $error("pin b does not follow error passive flag");
  a_f0_pin_b: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    sel_b == FTC_PICK_F0
    |=> o_pin_b == $past(i_int_flags[FTC_IF_F0]))
    else $error("pin b does not follow filter zero flag");
  a_bus_err_pin_a: assert property (
    @(posedge i_clk) disable iff (!i_rstn)
    sel_a == FTC_PICK_BUS_ERR
    |=> o_pin_a == $past(i_int_flags[FTC_IF_BUS_ERR]))
    else $error("pin a does not follow bus error flag");
endmodule : ftc_flag_pin_mux

// *** hw/ftc_time_tag_top.sv ***
`timescale 1ns/1ps
module ftc_time_tag_top (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // serial host port, mode 0
  input wire logic i_spi_sck,
  input wire logic i_spi_csn,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // bit clock tick from the bit timing logic
  input wire logic i_bit_tick,
  // flag registers
  input wire logic [7:0] i_int_flags,
  input wire logic [7:0] i_stat_flags,
  // flag output pins
  output logic o_flag_output_pin_a,
  output logic o_flag_output_pin_b
);
  import ftc_pkg::*;

  logic [1:0] rst_sync_q;
  logic rstn;
  logic sck_q;
  logic sck_rise;
  logic sck_fall;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_sh_q;
  logic byte_done;
  logic [7:0] rx_byte;
  ftc_spi_st_e st_q;
  logic [15:0] tx_sh_q;
  logic [7:0] sel_q;
  logic [7:0] ctl0_q;
  logic clr_q;
  logic [2:0] presc_q;
  logic [2:0] div_mask;
  logic advance;
  logic [FTC_CNT_W-1:0] count_q;
  logic decode;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rstn = rst_sync_q[1];

  // port pins are synchronous, so a one cycle delay gives the edges
  always_ff @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= i_spi_sck;
    end
  end
  assign sck_rise = !i_spi_csn && i_spi_sck && !sck_q;
  assign sck_fall = !i_spi_csn && !i_spi_sck && sck_q;
  assign byte_done = sck_rise && (bit_cnt_q == FTC_LAST_BIT);
  assign rx_byte = {rx_sh_q, i_spi_mosi};
  assign decode = byte_done && (st_q == FTC_ST_CMD);

  // a partial byte is dropped when select rises
  always_ff @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 3'h0;
      rx_sh_q <= 7'h00;
    end else if (i_spi_csn) begin
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_sh_q <= rx_byte[6:0];
    end
  end

  // command byte first, then data bytes until select rises
  always_ff @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= FTC_ST_CMD;
    end else if (i_spi_csn) begin
      st_q <= FTC_ST_CMD;
    end else if (byte_done) begin
      unique case (st_q)
        FTC_ST_CMD: begin
          unique case (rx_byte)
            FTC_OPC_RD_TIMER: st_q <= FTC_ST_SEND;
            FTC_OPC_RD_SEL: st_q <= FTC_ST_SEND;
            FTC_OPC_RD_CTL0: st_q <= FTC_ST_SEND;
            FTC_OPC_WR_SEL: st_q <= FTC_ST_WR_SEL;
            FTC_OPC_WR_CTL0: st_q <= FTC_ST_WR_CTL;
            default: st_q <= FTC_ST_SKIP;
          endcase
        end
        FTC_ST_WR_SEL: st_q <= FTC_ST_SKIP;
        FTC_ST_WR_CTL: st_q <= FTC_ST_SKIP;
        FTC_ST_SEND: st_q <= FTC_ST_SEND;
        FTC_ST_SKIP: st_q <= FTC_ST_SKIP;
      endcase
    end
  end

  // both count bytes are latched at once so a carry between them is harmless
  always_ff @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_sh_q <= 16'h0000;
      o_spi_miso <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end else if (i_spi_csn) begin
      o_spi_miso_oe <= 1'b0;
      o_spi_miso <= 1'b0;
    end else if (decode) begin
      unique case (rx_byte)
        FTC_OPC_RD_TIMER: tx_sh_q <= count_q;
        FTC_OPC_RD_SEL: tx_sh_q <= {sel_q, 8'h00};
        FTC_OPC_RD_CTL0: tx_sh_q <= {ctl0_q, 8'h00};
        default: tx_sh_q <= 16'h0000;
      endcase
    end else if (sck_fall && st_q == FTC_ST_SEND) begin
      o_spi_miso <= tx_sh_q[15];
      o_spi_miso_oe <= 1'b1;
      tx_sh_q <= {tx_sh_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= FTC_SEL_RST;
    end else if (byte_done && st_q == FTC_ST_WR_SEL) begin
      sel_q <= rx_byte;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl0_q <= FTC_CTL0_RST;
    end else if (byte_done && st_q == FTC_ST_WR_CTL) begin
      ctl0_q <= rx_byte;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      clr_q <= 1'b0;
    end else begin
      clr_q <= decode && (rx_byte == FTC_OPC_CLR_TIMER);
    end
  end

  assign div_mask = ftc_div_mask(ctl0_q[FTC_DIV_MSB:FTC_DIV_LSB]);
  assign advance = i_bit_tick && ((presc_q & div_mask) == div_mask);

  always_ff @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      presc_q <= 3'h0;
    end else if (clr_q) begin
      presc_q <= 3'h0;
    end else if (i_bit_tick) begin
      presc_q <= presc_q + 3'h1;
    end
  end

  // wrap is silent: no overflow flag exists
  always_ff @(posedge i_ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= FTC_CNT_RST;
    end else if (clr_q) begin
      count_q <= FTC_CNT_RST;
    end else if (advance) begin
      count_q <= count_q + 16'h0001;
    end
  end

  ftc_flag_pin_mux u_pin_mux (
    .i_clk(i_ref_clk),
    .i_rstn(rstn),
    .i_sel(sel_q),
    .i_int_flags(i_int_flags),
    .i_stat_flags(i_stat_flags),
    .o_pin_a(o_flag_output_pin_a),
    .o_pin_b(o_flag_output_pin_b)
  );

  a_count_step: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    advance && !clr_q |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not step by one");
  a_count_hold: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    !advance && !clr_q |=> $stable(count_q))
    else $error("counter moved without an advance");
  a_count_clear: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    decode && rx_byte == FTC_OPC_CLR_TIMER |=> ##1 count_q == FTC_CNT_RST)
    else $error("counter not cleared by clear command");
  a_presc_clear: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    clr_q |=> presc_q == 3'h0 && count_q == FTC_CNT_RST)
    else $error("clear left the counter or prescaler running");
  a_snap_count: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    decode && rx_byte == FTC_OPC_RD_TIMER |=> tx_sh_q == $past(count_q))
    else $error("count snapshot mismatch");
  a_div8_rate: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    advance && ctl0_q[FTC_DIV_MSB:FTC_DIV_LSB] == FTC_DIV_8 |-> presc_q == 3'h7)
    else $error("divide by eight advanced off phase");
  a_div2_rate: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    advance && ctl0_q[FTC_DIV_MSB:FTC_DIV_LSB] == FTC_DIV_2 |-> presc_q[0])
    else $error("divide by two advanced off phase");
  a_sel_write: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    byte_done && st_q == FTC_ST_WR_SEL |=> sel_q == $past(rx_byte))
    else $error("pin select write not stored");
  a_miso_idle: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    i_spi_csn |=> !o_spi_miso_oe)
    else $error("serial output driven while deselected");
  a_upper_first: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    st_q == FTC_ST_SEND && sck_fall && !i_spi_csn
    |=> o_spi_miso == $past(tx_sh_q[15]) && o_spi_miso_oe)
    else $error("serial output not msb first");
  a_tx_only_send: assert property (
    @(posedge i_ref_clk) disable iff (!rstn)
    $rose(o_spi_miso_oe) |-> $past(st_q) == FTC_ST_SEND && $past(sck_fall))
    else $error("output enabled outside a read");
endmodule : ftc_time_tag_top

// *** verif/ftc_spi_host.sv ***
`timescale 1ns/1ps
module ftc_spi_host (
  // clock
  input wire logic i_clk,
  // serial lines from the device
  input wire logic i_miso,
  input wire logic i_miso_oe,
  // serial lines to the device
  output logic o_sck,
  output logic o_csn,
  output logic o_mosi
);
  initial begin
    o_sck = 1'b0;
    o_csn = 1'b1;
    o_mosi = 1'b0;
  end

  // one command per select window, then nb data bytes taken from wd msb
  task automatic xfer(input logic [7:0] cmd, input int nb,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    int i;
    sh = {cmd, wd};
    rd = 16'h0000;
    @(posedge i_clk);
    #1 o_csn = 1'b0;
    for (i = 0; i < 8 * (nb + 1); i++) begin
      o_mosi = sh[23 - i];
      repeat (4) @(posedge i_clk);
      // a released line reads as the inverse of its last bit
      if (i >= 8) begin
        rd = {rd[14:0], i_miso_oe ? i_miso : ~rd[0]};
      end
      #1 o_sck = 1'b1;
      repeat (4) @(posedge i_clk);
      #1 o_sck = 1'b0;
    end
    repeat (4) @(posedge i_clk);
    #1 o_csn = 1'b1;
    o_mosi = ~o_mosi;
    repeat (2) @(posedge i_clk);
  endtask : xfer
endmodule : ftc_spi_host

// *** verif/flag_pins_and_time_tag_counter_bench.sv ***
`timescale 1ns/1ps
module flag_pins_and_time_tag_counter_bench;
  import ftc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic tick = 1'b0;
  logic [7:0] int_f = 8'h00;
  logic [7:0] stat_f = 8'h00;
  logic sck, csn, mosi, miso, miso_oe, pin_a, pin_b;
  logic watch = 1'b0;
  logic glitch = 1'b0;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  ftc_time_tag_top dut_u (
    .i_ref_clk(clk), .i_rstn(rstn),
    .i_spi_sck(sck), .i_spi_csn(csn), .i_spi_mosi(mosi),
    .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
    .i_bit_tick(tick), .i_int_flags(int_f), .i_stat_flags(stat_f),
    .o_flag_output_pin_a(pin_a), .o_flag_output_pin_b(pin_b)
  );

  ftc_spi_host host_u (
    .i_clk(clk), .i_miso(miso), .i_miso_oe(miso_oe),
    .o_sck(sck), .o_csn(csn), .o_mosi(mosi)
  );

  // wrap must leave the serial output enable and both flag pins quiet
  always @(posedge clk) begin
    if (watch && (miso_oe !== 1'b0 || pin_a !== 1'b0 || pin_b !== 1'b0)) begin
      glitch <= 1'b1;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      summarize();
    end
  end

  task automatic ticks(input int k);
    @(posedge clk);
    #1 tick = 1'b1;
    repeat (k) @(posedge clk);
    #1 tick = 1'b0;
  endtask : ticks

  task automatic rd_timer(output logic [15:0] v);
    host_u.xfer(FTC_OPC_RD_TIMER, 2, 16'hA5A5, v);
  endtask : rd_timer

  task automatic t_reset();
    logic [15:0] rd;
    host_u.xfer(FTC_OPC_RD_SEL, 1, 16'h0000, rd);
    chk("sel reset", {8'h00, FTC_SEL_RST}, rd);
    host_u.xfer(FTC_OPC_RD_CTL0, 1, 16'h0000, rd);
    chk("ctl0 reset", 16'h0000, rd);
    rd_timer(rd);
    chk("count reset", 16'h0000, rd);
    chk("pins reset", 16'h0000, {pin_a, pin_b});
    $display("test reset done");
  endtask : t_reset

  // only the chosen flag may light the pin, and within one cycle
  task automatic pin_case(input logic b_side, input logic [3:0] code,
                          input logic stat, input int bitn);
    logic [7:0] sel;
    logic [15:0] rd;
    sel = b_side ? {code, 4'h0} : {4'h0, code};
    host_u.xfer(FTC_OPC_WR_SEL, 1, {sel, 8'h00}, rd);
    host_u.xfer(FTC_OPC_RD_SEL, 1, 16'h0000, rd);
    chk("sel readback", {8'h00, sel}, rd);
    #1;
    if (stat) stat_f[bitn] = 1'b1;
    else int_f[bitn] = 1'b1;
    @(posedge clk);
    #1 chk("pin set", 16'h0001, b_side ? pin_b : pin_a);
    int_f = stat ? 8'hFF : ~(8'h01 << bitn);
    stat_f = stat ? ~(8'h01 << bitn) : 8'hFF;
    @(posedge clk);
    #1 chk("pin others", 16'h0000, b_side ? pin_b : pin_a);
    int_f = 8'h00;
    stat_f = 8'h00;
    @(posedge clk);
  endtask : pin_case

  task automatic t_pins();
    logic [15:0] rd;
    pin_case(1, FTC_PICK_F0, 0, FTC_IF_F0);
    pin_case(1, FTC_PICK_F1, 0, FTC_IF_F1);
    pin_case(1, FTC_PICK_WAKE, 0, FTC_IF_WAKE);
    pin_case(1, FTC_PICK_MODE_CHG, 0, FTC_IF_MODE_CHG);
    pin_case(1, FTC_PICK_RXQ, 0, FTC_IF_RXQ);
    pin_case(1, FTC_PICK_BUS_OFF, 1, FTC_SF_BUS_OFF);
    pin_case(1, FTC_PICK_ERR_PASV, 1, FTC_SF_ERR_PASV);
    pin_case(0, FTC_PICK_F0, 0, FTC_IF_F0);
    pin_case(0, FTC_PICK_BUS_ERR, 0, FTC_IF_BUS_ERR);
    pin_case(0, FTC_PICK_TXDONE, 0, FTC_IF_TXDONE);
    pin_case(0, FTC_PICK_RXQ, 0, FTC_IF_RXQ);
    pin_case(0, FTC_PICK_RXTEMP, 0, FTC_IF_RXTEMP);
    pin_case(0, FTC_PICK_RXFULL, 1, FTC_SF_RXFULL);
    pin_case(0, FTC_PICK_RXEMPTY, 1, FTC_SF_RXEMPTY);
    pin_case(0, FTC_PICK_TXHALF, 1, FTC_SF_TXHALF);
    pin_case(0, FTC_PICK_TXEMPTY, 1, FTC_SF_TXEMPTY);
    // spare selector codes keep both pins low whatever the flags do
    host_u.xfer(FTC_OPC_WR_SEL, 1, 16'hEE00, rd);
    #1 int_f = 8'hFF;
    stat_f = 8'hFF;
    repeat (2) @(posedge clk);
    #1 chk("pins spare code", 16'h0000, {pin_a, pin_b});
    int_f = 8'h00;
    stat_f = 8'h00;
    $display("test pins done");
  endtask : t_pins

  // 300 ticks at divide by one puts a nonzero upper byte on the wire to expose byte order
  task automatic t_div();
    logic [15:0] rd;
    int d;
    for (d = 0; d < 4; d++) begin
      host_u.xfer(FTC_OPC_WR_CTL0, 1, {6'h00, d[1:0], 8'h00}, rd);
      host_u.xfer(FTC_OPC_RD_CTL0, 1, 16'h0000, rd);
      chk("ctl0 readback", {14'h0000, d[1:0]}, rd);
      ticks(5);
      host_u.xfer(FTC_OPC_CLR_TIMER, 0, 16'h0000, rd);
      ticks(300);
      rd_timer(rd);
      chk("count div", 16'(300 >> d),
          rd);
    end
    host_u.xfer(FTC_OPC_WR_CTL0, 1, 16'h0000, rd);
    $display("test divider done");
  endtask : t_div

  task automatic t_wrap();
    logic [15:0] rd;
    host_u.xfer(FTC_OPC_WR_SEL, 1, 16'h0000, rd);
    host_u.xfer(FTC_OPC_CLR_TIMER, 0, 16'h0000, rd);
    #1 watch = 1'b1;
    ticks(65538);
    watch = 1'b0;
    chk("wrap quiet", 16'h0000, {15'h0000, glitch});
    rd_timer(rd);
    chk("count wrap", 16'h0002, rd);
    $display("test wrap done");
  endtask : t_wrap

  // count runs on during the read; late capture would drift far past 72
  task automatic t_snap();
    logic [15:0] rd;
    host_u.xfer(FTC_OPC_CLR_TIMER, 0, 16'h0000, rd);
    #1 tick = 1'b1;
    rd_timer(rd);
    #1 tick = 1'b0;
    chk("snapshot", 16'h0001, {15'h0000, rd >= 56 && rd <= 72});
    $display("test snapshot done");
  endtask : t_snap

  initial begin
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_pins();
    t_div();
    t_wrap();
    t_snap();
    summarize();
  end
endmodule : flag_pins_and_time_tag_counter_bench
